// ### scl_defines.vh
// Purpose: Constants for the bank command legality and power entry block
// Assumes: Four banks, 100 MHz core clock
// Notes:   Timing counts are in core_clk cycles unless named _NS
`ifndef SCL_DEFINES_VH
`define SCL_DEFINES_VH

// Bank states
`define SCL_ST_IDLE      3'h0
`define SCL_ST_ACTIVATE  3'h1
`define SCL_ST_ACTIVE    3'h2
`define SCL_ST_PRECHARGE 3'h3
`define SCL_ST_REFRESH   3'h4
`define SCL_ST_MODEREG   3'h5

// Commands as {ras_n, cas_n, we_n}
`define SCL_CMD_NOP      3'h7
`define SCL_CMD_ACT      3'h3
`define SCL_CMD_READ     3'h5
`define SCL_CMD_WRITE    3'h4
`define SCL_CMD_PRE      3'h2
`define SCL_CMD_REF      3'h1
`define SCL_CMD_MRS      3'h0
`define SCL_CMD_BST      3'h6

// Verdict codes
`define SCL_V_NOP        2'h0
`define SCL_V_LEGAL      2'h1
`define SCL_V_ILLEGAL    2'h2

// Power modes
`define SCL_PM_NORMAL    2'h0
`define SCL_PM_PDOWN     2'h1
`define SCL_PM_SREF      2'h2

// Default timings in ns and counts
`define SCL_TRCD_NS      20
`define SCL_TRP_NS       20
`define SCL_TRC_NS       60
`define SCL_TMRD_CYC     2
`define SCL_CLK_NS       10

`endif

// ### scl_bank_fsm.v
// Purpose: One bank state machine with its own timing counter
// Assumes: Commands here were already judged legal for this bank
// Notes:   Counter width fits the longest wait
`timescale 1ns/100ps
`include "scl_defines.vh"

module scl_bank_fsm #(
  parameter CW       = 4,
  parameter TRCD_CYC = 2,
  parameter TRP_CYC  = 2,
  parameter TRC_CYC  = 6
) (
  // Clock and reset
  input  wire         core_clk,
  input  wire         rst,
  // Control from the judge
  input  wire         do_act,
  input  wire         do_pre,
  input  wire         do_ref,
  input  wire         do_mrs,
  // Present state
  output wire [2:0]   state
);

  reg [2:0]    state_reg;
  reg [CW-1:0] cnt_reg;

  localparam TMRD_CYC = `SCL_TMRD_CYC;

  assign state = state_reg;

  // Bank state updated every rising edge
  always @(posedge core_clk) begin
    if (rst) begin
      state_reg <= `SCL_ST_IDLE;
      cnt_reg   <= {CW{1'b0}};
    end else begin
      case (state_reg)
        `SCL_ST_IDLE: begin
          if (do_act) begin
            state_reg <= `SCL_ST_ACTIVATE;
            cnt_reg   <= TRCD_CYC[CW-1:0] - 1'b1;
          end else if (do_ref) begin
            state_reg <= `SCL_ST_REFRESH;
            cnt_reg   <= TRC_CYC[CW-1:0] - 1'b1;
          end else if (do_mrs) begin
            state_reg <= `SCL_ST_MODEREG;
            cnt_reg   <= TMRD_CYC[CW-1:0] - 1'b1;
          end
        end
        `SCL_ST_ACTIVE: begin
          if (do_pre) begin
            state_reg <= `SCL_ST_PRECHARGE;
            cnt_reg   <= TRP_CYC[CW-1:0] - 1'b1;
          end
        end
        `SCL_ST_ACTIVATE: begin
          if (cnt_reg == {CW{1'b0}})
            state_reg <= `SCL_ST_ACTIVE;
          else
            cnt_reg <= cnt_reg - 1'b1;
        end
        `SCL_ST_PRECHARGE, `SCL_ST_REFRESH, `SCL_ST_MODEREG: begin
          if (cnt_reg == {CW{1'b0}})
            state_reg <= `SCL_ST_IDLE;
          else
            cnt_reg <= cnt_reg - 1'b1;
        end
        default: begin
          state_reg <= `SCL_ST_IDLE;
        end
      endcase
    end
  end

endmodule

// ### scl_judge.v
// Purpose: Classifies each command and tracks banks and power mode
// Assumes: Command pins already synchronous to core_clk
// Notes:   Verdict and state outputs are registered, one cycle late
`timescale 1ns/100ps
`include "scl_defines.vh"

module scl_judge #(
  parameter NBANK    = 4,
  parameter CW       = 4,
  parameter TRCD_CYC = (`SCL_TRCD_NS + `SCL_CLK_NS - 1) / `SCL_CLK_NS,
  parameter TRP_CYC  = (`SCL_TRP_NS + `SCL_CLK_NS - 1) / `SCL_CLK_NS,
  parameter TRC_CYC  = (`SCL_TRC_NS + `SCL_CLK_NS - 1) / `SCL_CLK_NS
) (
  // Clock and reset
  input  wire                 core_clk,
  input  wire                 rst,
  // Command pins from the controller
  input  wire                 cke,
  input  wire                 cs_n,
  input  wire                 ras_n,
  input  wire                 cas_n,
  input  wire                 we_n,
  input  wire [1:0]           bank_select,
  input  wire                 auto_precharge_flag,
  // Verdict
  output reg  [1:0]           verdict,
  output reg                  verdict_valid,
  // State view
  output reg  [3*NBANK-1:0]   bank_states,
  output reg                  all_idle,
  output reg  [1:0]           power_mode,
  output reg                  rx_enable
);

  reg                 cke_prev_reg;
  reg  [1:0]          pm_reg;
  reg  [CW-1:0]       sref_cnt_reg;
  wire [3*NBANK-1:0]  st;
  wire [NBANK-1:0]    idle_v;
  wire [NBANK-1:0]    pre_idle_v;
  reg  [NBANK-1:0]    act_v;
  reg  [NBANK-1:0]    pre_v;
  reg                 ref_go;
  reg                 mrs_go;
  reg  [1:0]          verdict_next;
  reg  [1:0]          pm_next;
  reg  [2:0]          sel_st;
  wire [2:0]          cmd;
  wire                all_idle_w;
  wire                normal;
  reg  [CW-1:0]       sref_cnt_next;
  wire                sref_exit;
  wire                sref_hold;

  assign cmd        = {ras_n, cas_n, we_n};
  assign all_idle_w = &idle_v;
  assign normal     = cke_prev_reg & (pm_reg == `SCL_PM_NORMAL);
  assign sref_exit  = (pm_reg == `SCL_PM_SREF) && (pm_next == `SCL_PM_NORMAL);
  assign sref_hold  = (sref_cnt_reg != {CW{1'b0}});

  // Exit hold: loaded so the first command lands one row cycle after exit
  always @* begin
    if (sref_exit)
      sref_cnt_next = TRC_CYC[CW-1:0] - 1'b1;
    else if (sref_hold)
      sref_cnt_next = sref_cnt_reg - 1'b1;
    else
      sref_cnt_next = sref_cnt_reg;
  end

  // Four bank machines
  genvar g;
  generate
    for (g = 0; g < NBANK; g = g + 1) begin : g_bank
      assign idle_v[g]     = (st[3*g+2:3*g] == `SCL_ST_IDLE);
      assign pre_idle_v[g] = idle_v[g] | (st[3*g+2:3*g] == `SCL_ST_PRECHARGE);
      scl_bank_fsm #(
        .CW       (CW),
        .TRCD_CYC (TRCD_CYC),
        .TRP_CYC  (TRP_CYC),
        .TRC_CYC  (TRC_CYC)
      ) u_bank (
        .core_clk (core_clk),
        .rst      (rst),
        .do_act   (act_v[g]),
        .do_pre   (pre_v[g]),
        .do_ref   (ref_go),
        .do_mrs   (mrs_go),
        .state    (st[3*g+2:3*g])
      );
    end
  endgenerate

  // Command decode against the selected bank
  always @* begin
    act_v        = {NBANK{1'b0}};
    pre_v        = {NBANK{1'b0}};
    ref_go       = 1'b0;
    mrs_go       = 1'b0;
    pm_next      = pm_reg;
    verdict_next = `SCL_V_NOP;
    sel_st       = st[3*bank_select +: 3];
    if (pm_reg != `SCL_PM_NORMAL) begin
      if (!cke_prev_reg && !cke) begin
        verdict_next = `SCL_V_NOP;
      end else if (!cke_prev_reg && cke) begin
        if (cs_n || cmd == `SCL_CMD_NOP) begin
          verdict_next = `SCL_V_LEGAL;
          pm_next      = `SCL_PM_NORMAL;
        end else begin
          verdict_next = `SCL_V_ILLEGAL;
        end
      end
    end else if (!cke_prev_reg) begin
      // Low-power entry refused and cke not yet sampled high: treat as quiet cycle
      verdict_next = `SCL_V_NOP;
    end else if (sref_hold) begin
      // Banks still inside the exit row cycle: only deselect or nop
      if (!cke || (!cs_n && cmd != `SCL_CMD_NOP))
        verdict_next = `SCL_V_ILLEGAL;
    end else if (normal && !cke) begin
      // Entering low power
      if (!all_idle_w) begin
        verdict_next = `SCL_V_ILLEGAL;
      end else if (cs_n || cmd == `SCL_CMD_NOP) begin
        verdict_next = `SCL_V_LEGAL;
        pm_next      = `SCL_PM_PDOWN;
      end else if (cmd == `SCL_CMD_REF) begin
        verdict_next = `SCL_V_LEGAL;
        pm_next      = `SCL_PM_SREF;
      end else begin
        verdict_next = `SCL_V_ILLEGAL;
      end
    end else if (!cs_n) begin
      case (cmd)
        `SCL_CMD_NOP: verdict_next = `SCL_V_NOP;
        `SCL_CMD_ACT: begin
          if (sel_st == `SCL_ST_IDLE) begin
            verdict_next           = `SCL_V_LEGAL;
            act_v[bank_select]     = 1'b1;
          end else begin
            verdict_next = `SCL_V_ILLEGAL;
          end
        end
        `SCL_CMD_READ, `SCL_CMD_WRITE, `SCL_CMD_BST: begin
          if (sel_st == `SCL_ST_ACTIVE)
            verdict_next = `SCL_V_LEGAL;
          else
            verdict_next = `SCL_V_ILLEGAL;
        end
        `SCL_CMD_PRE: begin
          if (auto_precharge_flag) begin
            pre_v        = ~pre_idle_v;
            verdict_next = (&pre_idle_v) ? `SCL_V_NOP : `SCL_V_LEGAL;
          end else if (pre_idle_v[bank_select]) begin
            verdict_next = `SCL_V_NOP;
          end else if (sel_st == `SCL_ST_ACTIVE) begin
            pre_v[bank_select] = 1'b1;
            verdict_next       = `SCL_V_LEGAL;
          end else begin
            verdict_next = `SCL_V_ILLEGAL;
          end
        end
        `SCL_CMD_REF, `SCL_CMD_MRS: begin
          if (all_idle_w) begin
            verdict_next = `SCL_V_LEGAL;
            ref_go       = (cmd == `SCL_CMD_REF);
            mrs_go       = (cmd == `SCL_CMD_MRS);
          end else begin
            verdict_next = `SCL_V_ILLEGAL;
          end
        end
        default: verdict_next = `SCL_V_ILLEGAL;
      endcase
    end
  end

  // Power mode, clock-enable history and registered outputs
  always @(posedge core_clk) begin
    if (rst) begin
      cke_prev_reg  <= 1'b1;
      pm_reg        <= `SCL_PM_NORMAL;
      sref_cnt_reg  <= {CW{1'b0}};
      verdict       <= `SCL_V_NOP;
      verdict_valid <= 1'b0;
      bank_states   <= {3*NBANK{1'b0}};
      all_idle      <= 1'b1;
      power_mode    <= `SCL_PM_NORMAL;
      rx_enable     <= 1'b1;
    end else begin
      cke_prev_reg  <= cke;
      pm_reg        <= pm_next;
      verdict       <= verdict_next;
      verdict_valid <= 1'b1;
      bank_states   <= st;
      // Self-refresh exit hold; idle drops at the exit edge itself
      sref_cnt_reg  <= sref_cnt_next;
      all_idle      <= all_idle_w && (sref_cnt_next == {CW{1'b0}});
      power_mode    <= pm_next;
      // Receivers on while cke is high or the next mode is normal, no wait for exit
      rx_enable     <= cke | (pm_next == `SCL_PM_NORMAL);
    end
  end

endmodule

// ### scl_judge_props.sv
// Purpose: Port assertions for the command judge
// Assumes: Default timing parameters on the judge
// Notes:   Attached to every judge by the bind below
`timescale 1ns/100ps
`include "scl_defines.vh"
module scl_judge_chk (
  // Clock and reset
  input wire        core_clk,
  input wire        rst,
  // Command pins
  input wire        cke,
  input wire        cs_n,
  input wire        ras_n,
  input wire        cas_n,
  input wire        we_n,
  input wire [1:0]  bank_select,
  input wire        auto_precharge_flag,
  // Judge outputs
  input wire [1:0]  verdict,
  input wire        verdict_valid,
  input wire [11:0] bank_states,
  input wire        all_idle,
  input wire [1:0]  power_mode,
  input wire        rx_enable
);
  reg        cq;
  wire [2:0] c = {ras_n, cas_n, we_n};
  wire [2:0] s = bank_states[bank_select*3 +: 3];
  wire       n = cq && cke && !cs_n && power_mode == `SCL_PM_NORMAL;
  // Clock enable seen at the previous edge
  always @(posedge core_clk) begin
    cq <= cke;
  end
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (rst);
  AST_CKE_LOW: assert property (!cq && !cke |=> verdict == `SCL_V_NOP)
    else $error("command not ignored in low power");
  AST_ACT: assert property (n && all_idle && c == `SCL_CMD_ACT && !bank_select
    |=> verdict == `SCL_V_LEGAL && bank_states[11:3] == 9'h000
    ##[1:3] bank_states[2:0] == `SCL_ST_ACTIVE)
    else $error("activate not tracked per bank");
  AST_RD_IDLE: assert property (n && c == `SCL_CMD_READ && s == `SCL_ST_IDLE
    |=> verdict == `SCL_V_ILLEGAL) else $error("read to idle bank passed");
  AST_PRE_IDLE: assert property (n && c == `SCL_CMD_PRE && !auto_precharge_flag
    && (s == `SCL_ST_IDLE || s == `SCL_ST_PRECHARGE) |=> verdict == `SCL_V_NOP)
    else $error("precharge to closed bank acted");
  AST_PRE_ALL: assert property (n && c == `SCL_CMD_PRE && auto_precharge_flag
    && !(bank_states & 12'hB6D) && (bank_states & 12'h492)
    |=> verdict == `SCL_V_LEGAL ##[0:3] bank_states == 12'h000)
    else $error("precharge all left a bank open");
  AST_REF_BUSY: assert property (n && c == `SCL_CMD_REF && !all_idle
    |=> verdict == `SCL_V_ILLEGAL) else $error("refresh with open bank passed");
  AST_PD_IN: assert property (cq && !cke && all_idle && power_mode == 2'h0
    && (cs_n || c == `SCL_CMD_NOP) |=> power_mode == `SCL_PM_PDOWN)
    else $error("power-down not entered");
  AST_NO_ENTRY: assert property (cq && !cke && !all_idle
    |=> power_mode == `SCL_PM_NORMAL) else $error("low power entered while busy");
  AST_SR_EXIT: assert property (power_mode == `SCL_PM_SREF && !cq && cke
    && (cs_n || c == `SCL_CMD_NOP) |=> power_mode == `SCL_PM_NORMAL
    ##0 !all_idle [*5] ##[1:2] all_idle) else $error("self-refresh exit hold wrong");
endmodule
bind scl_judge scl_judge_chk u_chk (.core_clk(core_clk), .rst(rst), .cke(cke),
  .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .bank_select(bank_select),
  .auto_precharge_flag(auto_precharge_flag), .verdict(verdict),
  .verdict_valid(verdict_valid), .bank_states(bank_states), .all_idle(all_idle),
  .power_mode(power_mode), .rx_enable(rx_enable));

// ### scl_ctrl_model.sv
// Purpose: Controller model driving the command pins
// Assumes: Caller spaces commands by the bank timing
// Notes:   Released pins show the inverse of the last value
`timescale 1ns/100ps
module scl_ctrl_model (
  // Clock
  input wire        core_clk,
  // Command pins
  output reg        cke,
  output reg        cs_n,
  output reg        ras_n,
  output reg        cas_n,
  output reg        we_n,
  output reg [1:0]  bank_select,
  output reg        auto_precharge_flag
);
  integer init_seed = 32'h9a3ee836;
  integer init_r;
  // Deselected at time zero; bank and flag pins start at a random level
  initial begin
    {cke, cs_n, ras_n, cas_n, we_n} = 5'h1F;
    init_r = $random(init_seed);
    {bank_select, auto_precharge_flag} = init_r[2:0];
  end
  // One command edge then a deselect gap; cke takes the given level with any command and holds it
  task send(input k, input [2:0] c, input [1:0] b, input a);
    begin
      @(posedge core_clk);
      cke <= k;
      cs_n <= 1'b0;
      {ras_n, cas_n, we_n} <= c;
      bank_select <= b;
      auto_precharge_flag <= a;
      @(posedge core_clk);
      cs_n <= 1'b1;
      {ras_n, cas_n, we_n} <= ~c;
      bank_select <= ~b;
      auto_precharge_flag <= ~a;
    end
  endtask
  // Quiet cycles, also the setup wait after waking
  task idle(input integer n);
    begin
      repeat (n) @(posedge core_clk);
    end
  endtask
endmodule

// ### tb_top.sv
// Purpose: Self-checking bench for the command judge
// Assumes: Default judge timing, one clock
// Notes:   Random commands settle 8 cycles before bank views are checked
`timescale 1ns/100ps
`include "scl_defines.vh"
module tb_top;
  reg         core_clk = 1'b0;
  reg         rst = 1'b1;
  wire        cke, cs_n, ras_n, cas_n, we_n, auto_precharge_flag;
  wire        verdict_valid, all_idle, rx_enable;
  wire [1:0]  bank_select, verdict, power_mode;
  wire [11:0] bank_states;
  integer     err_total = 0;
  integer     check_count = 0;
  integer     cyc = 0;
  integer     seed = 32'h9a3ee836;
  integer     i;
  reg [2:0]   c;
  reg [1:0]   b;
  reg         a;
  reg [11:0]  m = 12'h000;

  scl_ctrl_model ctl (.core_clk(core_clk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .bank_select(bank_select),
    .auto_precharge_flag(auto_precharge_flag));
  scl_judge dut (.core_clk(core_clk), .rst(rst), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .bank_select(bank_select),
    .auto_precharge_flag(auto_precharge_flag), .verdict(verdict),
    .verdict_valid(verdict_valid), .bank_states(bank_states), .all_idle(all_idle),
    .power_mode(power_mode), .rx_enable(rx_enable));

  // Clock and hang guard
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      err_total = err_total + 1;
      complete_run;
    end
  end
  // Value compare
  task chk(input [11:0] got, input [11:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // Command and its verdict one cycle later
  task cmd(input k, input [2:0] cc, input [1:0] bb, input aa, input [1:0] ev);
    begin
      ctl.send(k, cc, bb, aa);
      #1;
      chk({9'h000, verdict_valid, verdict}, {9'h000, 1'b1, ev});
    end
  endtask
  // Expected verdict from the bank model
  function [1:0] exp_v(input [2:0] cc, input [1:0] bb, input aa, input [11:0] mm);
    begin
      case (cc)
        `SCL_CMD_ACT: exp_v = mm[bb*3 +: 3] == 3'h0 ? `SCL_V_LEGAL : `SCL_V_ILLEGAL;
        `SCL_CMD_READ, `SCL_CMD_WRITE:
          exp_v = mm[bb*3 +: 3] == 3'h2 ? `SCL_V_LEGAL : `SCL_V_ILLEGAL;
        `SCL_CMD_PRE: exp_v = (aa ? mm != 0 : mm[bb*3 +: 3] != 0) ? `SCL_V_LEGAL : `SCL_V_NOP;
        default: exp_v = mm == 12'h000 ? `SCL_V_LEGAL : `SCL_V_ILLEGAL;
      endcase
    end
  endfunction
  // Verdict and end of run
  task complete_run;
    begin
      $display("errors %0d checks %0d", err_total, check_count);
      if (err_total == 0 && check_count > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  // Directed corners, then random traffic
  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    cmd(1'b1, `SCL_CMD_ACT, 2'h0, 1'b0, `SCL_V_LEGAL);
    cmd(1'b1, `SCL_CMD_ACT, 2'h1, 1'b0, `SCL_V_LEGAL);
    cmd(1'b1, `SCL_CMD_ACT, 2'h0, 1'b0, `SCL_V_ILLEGAL);
    cmd(1'b1, `SCL_CMD_REF, 2'h2, 1'b0, `SCL_V_ILLEGAL);
    ctl.send(1'b0, `SCL_CMD_NOP, 2'h0, 1'b0);
    #1 chk({10'h000, power_mode}, {10'h000, `SCL_PM_NORMAL});
    ctl.send(1'b1, `SCL_CMD_NOP, 2'h0, 1'b0);
    ctl.idle(2);
    cmd(1'b1, `SCL_CMD_PRE, 2'h3, 1'b1, `SCL_V_LEGAL);
    ctl.idle(8);
    ctl.send(1'b0, `SCL_CMD_NOP, 2'h0, 1'b0);
    #1 chk({9'h000, rx_enable, power_mode}, {9'h000, 1'b0, `SCL_PM_PDOWN});
    cmd(1'b0, `SCL_CMD_ACT, 2'h3, 1'b0, `SCL_V_NOP);
    ctl.send(1'b1, `SCL_CMD_NOP, 2'h0, 1'b0);
    #1 chk({bank_states[10:0], rx_enable}, 12'h001);
    ctl.idle(2);
    ctl.send(1'b0, `SCL_CMD_REF, 2'h0, 1'b0);
    #1 chk({10'h000, power_mode}, {10'h000, `SCL_PM_SREF});
    ctl.idle(3);
    ctl.send(1'b1, `SCL_CMD_NOP, 2'h0, 1'b0);
    #1 chk({11'h000, all_idle}, 12'h000);
    cmd(1'b1, `SCL_CMD_ACT, 2'h0, 1'b0, `SCL_V_ILLEGAL);
    ctl.idle(7);
    #1 chk({11'h000, all_idle}, 12'h001);
    for (i = 0; i < 150; i = i + 1) begin
      c = $random(seed);
      b = $random(seed);
      a = $random(seed);
      if (c == `SCL_CMD_NOP || c == `SCL_CMD_BST)
        c = `SCL_CMD_ACT;
      cmd(1'b1, c, b, a, exp_v(c, b, a, m));
      if (c == `SCL_CMD_ACT && m[b*3 +: 3] == 3'h0)
        m[b*3 +: 3] = 3'h2;
      if (c == `SCL_CMD_PRE)
        m = a ? 12'h000 : m & ~(12'h007 << (b * 3));
      ctl.idle(8);
      #1 chk(bank_states, m);
    end
    complete_run;
  end
endmodule
